// *** rtl/move_or_literal_exec.sv ***
// Execution unit for OR-with-file, moves, literal load, option load and no-operation
`timescale 1ns/1ns
`default_nettype none

module move_or_literal_exec
(
   // Clock and reset
   input  wire logic                            clk_i,
   input  wire logic                            reset_n_i,
   // Instruction from decoder (same clock domain)
   input  wire exec_pkg::insn_t                 insn_i,
   // Architectural state
   output logic      [exec_pkg::DATA_W-1:0]     acc_o,
   output logic      [exec_pkg::DATA_W-1:0]     option_o,
   output logic                                 zero_o,
   // Completion
   output exec_pkg::exec_status_t               status_o,
   // Last file write, for observation
   output exec_pkg::file_wr_t                   file_wr_o
);
   import exec_pkg::*;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } state_t;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   function automatic op_t decode(input logic [INSN_W-1:0] w);
      op_t op;
      op = OP_OTHER;
      if (w == NOP_WORD)
         op = OP_NOP;
      else if (w == OPTION_WORD)
         op = OP_OPTION;
      else if (w[11:5] == MOVE_ACC_TO_FILE_OP)
         op = OP_MOVE_ACC;
      else if (w[11:6] == OR_ACC_WITH_FILE_OP)
         op = OP_OR;
      else if (w[11:6] == MOVE_FILE_OP)
         op = OP_MOVE_FILE;
      else if (w[11:8] == LOAD_LITERAL_OP)
         op = OP_LIT;
      return op;
   endfunction

   state_t            state_ff;
   state_t            nxt_state;
   op_t               op_ff;
   op_t               nxt_op;
   logic [INSN_W-1:0] word_ff;
   logic [INSN_W-1:0] nxt_word;
   logic [DATA_W-1:0] acc_ff;
   logic [DATA_W-1:0] nxt_acc;
   logic [DATA_W-1:0] option_ff;
   logic [DATA_W-1:0] nxt_option;
   logic              zero_ff;
   logic              nxt_zero;
   exec_status_t      status_ff;
   exec_status_t      nxt_status;
   file_wr_t          wr_ff;
   file_wr_t          nxt_wr;
   file_wr_t          mem_wr;
   logic [DATA_W-1:0] file_rd;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] result;
   logic              dest_file;
   logic [ADDR_W-1:0] f_addr;

   assign rd_addr   = insn_i.word[ADDR_LSB +: ADDR_W];
   assign f_addr    = word_ff[ADDR_LSB +: ADDR_W];
   assign dest_file = word_ff[DEST_BIT];

   file_mem u_file
   (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .wr_i      (mem_wr),
      .rd_addr_i (rd_addr),
      .rd_data_o (file_rd)
   );

   // ------------------------------------------------------------
   // Next state: fetch cycle reads file, execute cycle writes
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_state  = state_ff;
      nxt_op     = op_ff;
      nxt_word   = word_ff;
      nxt_acc    = acc_ff;
      nxt_option = option_ff;
      nxt_zero   = zero_ff;
      nxt_status = '0;
      nxt_wr     = wr_ff;
      nxt_wr.we  = 1'b0;
      mem_wr     = '0;
      result     = '0;
      case (state_ff)
         ST_IDLE:
         begin
            if (insn_i.valid)
            begin
               nxt_op    = decode(insn_i.word);
               nxt_word  = insn_i.word;
               nxt_state = ST_EXEC;
            end
         end
         ST_EXEC:
         begin
            nxt_state         = ST_IDLE;
            nxt_status.done   = 1'b1;
            nxt_status.pc_inc = 1'b1;
            case (op_ff)
               OP_OR:
               begin
                  result   = acc_ff | file_rd;
                  nxt_zero = (result == '0);
                  if (dest_file)
                     mem_wr = '{we: 1'b1, addr: f_addr, data: result};
                  else
                     nxt_acc = result;
               end
               OP_MOVE_ACC:
               begin
                  mem_wr = '{we: 1'b1, addr: f_addr, data: acc_ff};
               end
               OP_MOVE_FILE:
               begin
                  result   = file_rd;
                  nxt_zero = (result == '0);
                  if (dest_file)
                     mem_wr = '{we: 1'b1, addr: f_addr, data: result};
                  else
                     nxt_acc = result;
               end
               OP_LIT:
               begin
                  nxt_acc = word_ff[LIT_LSB +: DATA_W];
               end
               OP_OPTION:
               begin
                  nxt_option = acc_ff;
               end
               OP_NOP:
               begin
                  nxt_status.pc_inc = 1'b1;
               end
               default:
               begin
                  nxt_status.illegal = 1'b1;
               end
            endcase
            if (mem_wr.we)
               nxt_wr = mem_wr;
         end
         default:
         begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         state_ff  <= ST_IDLE;
         op_ff     <= OP_NOP;
         word_ff   <= NOP_WORD;
         acc_ff    <= ACC_RST;
         option_ff <= OPTION_RST;
         zero_ff   <= ZERO_RST;
         status_ff <= '0;
         wr_ff     <= '0;
      end
      else
      begin
         state_ff  <= nxt_state;
         op_ff     <= nxt_op;
         word_ff   <= nxt_word;
         acc_ff    <= nxt_acc;
         option_ff <= nxt_option;
         zero_ff   <= nxt_zero;
         status_ff <= nxt_status;
         wr_ff     <= nxt_wr;
      end
   end

   assign acc_o     = acc_ff;
   assign option_o  = option_ff;
   assign zero_o    = zero_ff;
   assign status_o  = status_ff;
   assign file_wr_o = wr_ff;

endmodule
`default_nettype wire

// *** rtl/exec_pkg.sv ***
// Package with constants, encodings and carriers for the move/OR/literal execution block
package exec_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int DATA_W  = 8;
   localparam int ADDR_W  = 5;
   localparam int INSN_W  = 12;
   localparam int DEPTH   = 32;

   // ------------------------------------------------------------
   // Instruction encodings (12-bit words)
   // ------------------------------------------------------------
   localparam logic [INSN_W-1:0] NOP_WORD     = 12'h000;
   localparam logic [INSN_W-1:0] OPTION_WORD  = 12'h002;
   localparam logic [6:0]        MOVE_ACC_TO_FILE_OP = 7'h01;  // 0000_001f_ffff
   localparam logic [5:0]        OR_ACC_WITH_FILE_OP = 6'h04;  // 0001_00df_ffff
   localparam logic [5:0]        MOVE_FILE_OP        = 6'h08;  // 0010_00df_ffff
   localparam logic [3:0]        LOAD_LITERAL_OP     = 4'hc;   // 1100_kkkk_kkkk

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int DEST_BIT   = 5;
   localparam int ADDR_LSB   = 0;
   localparam int LIT_LSB    = 0;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
   localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
   localparam logic [DATA_W-1:0] FILE_RST   = 8'h00;
   localparam logic              ZERO_RST   = 1'b0;

   // ------------------------------------------------------------
   // Decoded operations
   // ------------------------------------------------------------
   typedef enum logic [6:0]
   {
      OP_NOP     = 7'h01,
      OP_OR      = 7'h02,
      OP_MOVE_ACC  = 7'h04,
      OP_MOVE_FILE = 7'h08,
      OP_LIT     = 7'h10,
      OP_OPTION  = 7'h20,
      OP_OTHER   = 7'h40
   } op_t;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic              valid;
      logic [INSN_W-1:0] word;
   } insn_t;

   typedef struct packed
   {
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } file_wr_t;

   typedef struct packed
   {
      logic              done;
      logic              pc_inc;
      logic              illegal;
   } exec_status_t;

endpackage

// *** rtl/file_mem.sv ***
// Register file: 32 bytes, one write port, one registered read port
`timescale 1ns/1ns
`default_nettype none

module file_mem
(
   // Clock and reset
   input  wire logic                            clk_i,
   input  wire logic                            reset_n_i,
   // Write port
   input  wire exec_pkg::file_wr_t              wr_i,
   // Read port
   input  wire logic [exec_pkg::ADDR_W-1:0]     rd_addr_i,
   output logic      [exec_pkg::DATA_W-1:0]     rd_data_o
);
   import exec_pkg::*;

   logic [DATA_W-1:0] mem_ff     [DEPTH];
   logic [DATA_W-1:0] nxt_mem    [DEPTH];
   logic [DATA_W-1:0] rd_data_ff;
   logic [DATA_W-1:0] nxt_rd_data;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < DEPTH; i++)
      begin
         nxt_mem[i] = mem_ff[i];
      end
      if (wr_i.we)
      begin
         nxt_mem[wr_i.addr] = wr_i.data;
      end
      nxt_rd_data = mem_ff[rd_addr_i];
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_ff[i] <= FILE_RST;
         end
         rd_data_ff <= FILE_RST;
      end
      else
      begin
         mem_ff     <= nxt_mem;
         rd_data_ff <= nxt_rd_data;
      end
   end

   assign rd_data_o = rd_data_ff;

endmodule
`default_nettype wire

// *** verification/move_or_literal_exec_chk.sv ***
// Checker for the execution unit's results and timing
`timescale 1ns/1ns
`default_nettype none

module move_or_literal_exec_chk
(
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   reset_n_i,
   // Watched ports
   input  wire exec_pkg::insn_t        insn_i,
   input  wire logic [7:0]             acc_o,
   input  wire logic [7:0]             option_o,
   input  wire logic                   zero_o,
   input  wire exec_pkg::exec_status_t status_o,
   input  wire exec_pkg::file_wr_t     file_wr_o
);
   import exec_pkg::*;
   logic        busy_ff;
   logic        take;
   logic [11:0] w;
   logic [4:0]  fa;
   assign w = insn_i.word;
   assign fa = w[4:0];
   assign take = insn_i.valid && !busy_ff;
   // Mirrors the idle/execute alternation of the unit
   always_ff @(posedge clk_i)
   begin
      busy_ff <= reset_n_i && take;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // ------------------------------------------------------------
   // Sequences
   // ------------------------------------------------------------
   sequence s_lit; take && w[11:8] == LOAD_LITERAL_OP; endsequence
   sequence s_or(d); take && w[11:6] == OR_ACC_WITH_FILE_OP && w[5] == d; endsequence
   sequence s_mvf(d); take && w[11:6] == MOVE_FILE_OP && w[5] == d; endsequence
   sequence s_mvw; take && w[11:5] == MOVE_ACC_TO_FILE_OP; endsequence
   sequence s_opt; take && w == OPTION_WORD; endsequence
   sequence s_nop; take && w == NOP_WORD; endsequence
   sequence s_ack; status_o.done && status_o.pc_inc; endsequence
   sequence s_ill;
      take && !(w == NOP_WORD || w == OPTION_WORD || w[11:5] == MOVE_ACC_TO_FILE_OP
         || w[11:6] == OR_ACC_WITH_FILE_OP || w[11:6] == MOVE_FILE_OP
         || w[11:8] == LOAD_LITERAL_OP);
   endsequence
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   property p_done; take |-> ##2 s_ack; endproperty
   property p_lit;
      s_lit |-> ##2 $past(w, 2) == {LOAD_LITERAL_OP, acc_o} && $stable(zero_o);
   endproperty
   property p_opt;
      s_opt |-> ##2 option_o == $past(acc_o) && $stable(zero_o) && $stable(acc_o);
   endproperty
   property p_mvw;
      s_mvw |-> ##2 file_wr_o.we && file_wr_o.addr == $past(fa, 2)
         && file_wr_o.data == $past(acc_o) && $stable(zero_o);
   endproperty
   property p_or1;
      s_or(1) |-> ##2 file_wr_o.we && (file_wr_o.data | $past(acc_o)) == file_wr_o.data
         && file_wr_o.addr == $past(fa, 2) && $stable(acc_o)
         && zero_o == (file_wr_o.data == 8'h00);
   endproperty
   property p_or0;
      s_or(0) |-> ##2 !file_wr_o.we && (acc_o | $past(acc_o)) == acc_o
         && zero_o == (acc_o == 8'h00);
   endproperty
   property p_mvf1;
      s_mvf(1) |-> ##2 file_wr_o.we && file_wr_o.addr == $past(fa, 2) && $stable(acc_o)
         && zero_o == (file_wr_o.data == 8'h00);
   endproperty
   property p_mvf0; s_mvf(0) |-> ##2 !file_wr_o.we && zero_o == (acc_o == 8'h00); endproperty
   property p_nop;
      s_nop |-> ##2 !file_wr_o.we && $stable(acc_o) && $stable(option_o) && $stable(zero_o);
   endproperty
   property p_ill;
      s_ill |-> ##2 status_o.illegal && !file_wr_o.we && $stable(acc_o) && $stable(option_o)
         && $stable(zero_o);
   endproperty
   property p_we; file_wr_o.we |-> status_o.done; endproperty
   a_done: assert property (p_done) else $error("no done two cycles after take");
   a_ill: assert property (p_ill) else $error("unknown word changed state");
   a_we: assert property (p_we) else $error("file write strobe outside execute");
   a_lit: assert property (p_lit) else $error("literal load wrong");
   a_opt: assert property (p_opt) else $error("option load wrong");
   a_mvw: assert property (p_mvw) else $error("acc to file move wrong");
   a_or1: assert property (p_or1) else $error("or to file wrong");
   a_or0: assert property (p_or0) else $error("or to acc wrong");
   a_mvf1: assert property (p_mvf1) else $error("file move back wrong");
   a_mvf0: assert property (p_mvf0) else $error("file move to acc wrong");
   a_nop: assert property (p_nop) else $error("no-op changed state");
endmodule

bind move_or_literal_exec move_or_literal_exec_chk chk_i (.clk_i(clk_i),
   .reset_n_i(reset_n_i), .insn_i(insn_i), .acc_o(acc_o), .option_o(option_o),
   .zero_o(zero_o), .status_o(status_o), .file_wr_o(file_wr_o));
`default_nettype wire

// *** verification/move_or_literal_exec_tb.sv ***
// Random and corner-case bench of the execution unit
`timescale 1ns/1ns
`default_nettype none

module move_or_literal_exec_tb;
   import exec_pkg::*;
   logic         clk_i;
   logic         reset_n_i;
   logic         zero_o;
   logic         z;
   insn_t        insn_i;
   logic [7:0]   acc_o, option_o, acc, opt, rd;
   logic [7:0]   mem [32];
   logic [11:0]  cw [13] = '{12'hc00, 12'h03f, 12'h220, 12'hcff, 12'h001, 12'h002, 12'h11f,
                           12'h000, 12'h21f, 12'hc00, 12'h125, 12'h025, 12'hfff};
   exec_status_t status_o;
   file_wr_t     file_wr_o;
   int           bad_count, checked, k;
   logic [31:0]  r;
   logic [11:0]  w;

   move_or_literal_exec uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .insn_i(insn_i),
      .acc_o(acc_o), .option_o(option_o), .zero_o(zero_o), .status_o(status_o),
      .file_wr_o(file_wr_o));

   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      checked++;
      if (s !== e)
      begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask

   // Reference model: updates state, returns whether a file write is due
   function automatic logic model(logic [11:0] x);
      logic orf, mvf, mvw, wr;
      orf = x[11:6] == OR_ACC_WITH_FILE_OP;
      mvf = x[11:6] == MOVE_FILE_OP;
      mvw = x[11:5] == MOVE_ACC_TO_FILE_OP;
      rd = orf ? (mem[x[4:0]] | acc) : (mvw ? acc : mem[x[4:0]]);
      wr = mvw || ((orf || mvf) && x[5]);
      if (orf || mvf) z = rd == 8'h00;
      if ((orf || mvf) && !x[5]) acc = rd;
      if (x == OPTION_WORD) opt = acc;
      if (x[11:8] == LOAD_LITERAL_OP) acc = x[7:0];
      if (wr) mem[x[4:0]] = rd;
      return wr;
   endfunction

   // Words that the unit executes; anything else is flagged illegal
   function automatic logic known(logic [11:0] x);
      return x == NOP_WORD || x == OPTION_WORD || x[11:5] == MOVE_ACC_TO_FILE_OP
         || x[11:6] == OR_ACC_WITH_FILE_OP || x[11:6] == MOVE_FILE_OP
         || x[11:8] == LOAD_LITERAL_OP;
   endfunction

   // Reset for n edges, then check the reset state
   task automatic do_reset(int n);
      insn_i = '0;
      reset_n_i = 1'b0;
      acc = ACC_RST;
      opt = OPTION_RST;
      z = ZERO_RST;
      foreach (mem[i]) mem[i] = FILE_RST;
      repeat (n) @(posedge clk_i);
      #5 reset_n_i = 1'b1;
      @(posedge clk_i) #5;
      chk("acc_rst", acc, acc_o);
      chk("opt_rst", opt, option_o);
      chk("zero_rst", {7'h00, z}, {7'h00, zero_o});
   endtask

   // One instruction; h keeps valid up through the refused execute cycle
   task automatic run(logic [11:0] x, logic h);
      logic wr;
      logic ill;
      ill = !known(x);
      wr = model(x);
      insn_i = '{1'b1, x};
      @(posedge clk_i) #5;
      insn_i.valid = h;
      @(posedge clk_i) #5;
      chk("done", 8'h01, {7'h00, status_o.done});
      chk("illegal", {7'h00, ill}, {7'h00, status_o.illegal});
      chk("pc_inc", 8'h01, {7'h00, status_o.pc_inc});
      chk("we", {7'h00, wr}, {7'h00, file_wr_o.we});
      if (wr) chk("addr", {3'h0, x[4:0]}, {3'h0, file_wr_o.addr});
      if (wr) chk("data", rd, file_wr_o.data);
      chk("acc", acc, acc_o);
      chk("option", opt, option_o);
      chk("zero", {7'h00, z}, {7'h00, zero_o});
   endtask

   task automatic give_verdict;
      if (bad_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      #200000;
      bad_count++;
      give_verdict;
   end

   initial
   begin
      void'($urandom(76737));
      do_reset(20);
      foreach (cw[i]) run(cw[i], i == 3);
      do_reset(2);
      repeat (400)
      begin
         k = $urandom_range(6);
         r = $urandom;
         w = k == 0 ? {LOAD_LITERAL_OP, r[7:0]} : k == 1 ? {MOVE_ACC_TO_FILE_OP, r[4:0]}
           : k == 2 ? {OR_ACC_WITH_FILE_OP, r[5:0]} : k == 3 ? {MOVE_FILE_OP, r[5:0]}
           : k == 4 ? OPTION_WORD : k == 5 ? NOP_WORD : r[11:0];
         run(w, r[11:8] == 4'h0);
      end
      give_verdict;
   end
endmodule
`default_nettype wire
